// File: hw/rfsw_pkg.sv
package rfsw_pkg;
	// register addresses seen by the serial bus
	localparam logic [15:0] ADDR_PATH_SELECTOR_FIELD = 16'h0000;  // switch path control
	localparam logic [15:0] ADDR_SPARE   = 16'h0001;  // spare storage
	localparam logic [15:0] ADDR_STATUS  = 16'h001a;  // bus error and soft reset
	// reset values
	localparam logic [7:0]  RST_PATH_SELECTOR_FIELD  = 8'h00;     // isolated, spare nibble clear
	localparam logic [7:0]  RST_SPARE    = 8'h00;
	localparam logic [6:0]  RST_FLAGS    = 7'h00;
	// field layout
	localparam int          SEL_MSB      = 3;         // path selector in low nibble
	localparam int          BIT_SOFT_RST = 7;         // soft reset bit of status
	localparam int          BIT_CMD_PAR  = 6;
	localparam int          BIT_SEQ_LEN  = 5;
	localparam int          BIT_ADR_PAR  = 4;
	localparam int          BIT_DAT_PAR  = 3;
	localparam int          BIT_BAD_RD   = 2;
	localparam int          BIT_BAD_WR   = 1;
	localparam int          BIT_SHR_RD   = 0;
	localparam int          FLAG_W       = 7;
	localparam int          TRIG_W       = 3;         // triggers zero to two
	// selector codes and throw enables
	localparam logic [3:0]  SEL_ISO      = 4'h0;
	localparam logic [3:0]  SEL_ONE      = 4'h1;
	localparam logic [3:0]  SEL_TWO      = 4'h2;
	localparam logic [3:0]  SEL_THREE    = 4'h4;
	localparam logic [3:0]  SEL_FOUR     = 4'h8;
	localparam logic [3:0]  THROW_NONE   = 4'h0;
endpackage

// File: hw/rfsw_regs.sv
`timescale 1ns/1ps
// Overview of operation
// - selector code one-hot picks exactly one throw
// - switch control resets zero, trigger shadowed
// - spare nibble and spare register plain storage
// - writing soft reset bit resets user registers
// - soft reset clears status and user registers
// - soft reset bit always reads zero
// - command parity error sets bit six
// - wrong sequence length sets bit five
// - address parity error sets bit four
// - data parity error sets bit three
// - read of unimplemented address sets bit two
// - write of unimplemented address sets bit one
// - broadcast or group read sets bit zero
// - reading status clears its flags
// - unmasked trigger writes shadow, trigger loads
// - low power isolates, startup resets all registers except the read answer registers
module rfsw_regs
	import rfsw_pkg::*;
(
	input  wire logic              clk_in,                  // 50 MHz system clock
	input  wire logic              reset_n_in,              // synchronous, supply reset
	input  wire logic              acc_write_in,            // decoded write pulse
	input  wire logic              acc_read_in,             // decoded read pulse
	input  wire logic              acc_broadcast_in,        // access used shared id
	input  wire logic              acc_claimed_in,          // address owned elsewhere
	input  wire logic [15:0]       acc_addr_in,             // register address
	input  wire logic [7:0]        acc_wdata_in,            // write data
	input  wire logic              err_cmd_parity_in,       // command frame parity bad
	input  wire logic              err_seq_length_in,       // sequence length bad
	input  wire logic              err_addr_parity_in,      // address frame parity bad
	input  wire logic              err_data_parity_in,      // data frame parity bad
	input  wire logic [TRIG_W-1:0] trigger_load_in,         // trigger bits written
	input  wire logic [TRIG_W-1:0] trigger_disable_bits_in, // trigger mask level
	input  wire logic              power_low_in,            // low power active state
	input  wire logic              power_startup_in,        // startup code written
	output logic [7:0]             acc_rdata_out,           // read data
	output logic                   acc_rvalid_out,          // read data valid pulse
	output logic [3:0]             throw_port_en_out        // throw one..four enables
);

	logic [7:0]        path_selector_field_reg;      // active switch control
	logic [7:0]        sw_shadow_reg;    // shadow of switch control
	logic [7:0]        spare_reg;        // active spare storage
	logic [7:0]        spare_shadow_reg; // shadow of spare storage
	logic [FLAG_W-1:0] flags_reg;        // status flags six..zero
	logic [FLAG_W-1:0] flags_next;
	logic [3:0]        throw_next;
	logic [7:0]        rdata_next;

	// address decode
	wire hit_sw     = (acc_addr_in == ADDR_PATH_SELECTOR_FIELD);
	wire hit_spare  = (acc_addr_in == ADDR_SPARE);
	wire hit_status = (acc_addr_in == ADDR_STATUS);
	wire hit_own    = hit_sw | hit_spare | hit_status;
	wire addr_ok    = hit_own | acc_claimed_in;

	// full reset: supply reset or a startup power code
	wire full_rst   = ~reset_n_in | power_startup_in;
	// soft reset on a write of one to the soft reset bit
	wire soft_rst   = acc_write_in & hit_status & acc_wdata_in[BIT_SOFT_RST];
	wire any_rst    = full_rst | soft_rst;

	// shadow scheme: direct only when every associated trigger is masked
	wire direct_wr  = &trigger_disable_bits_in;
	wire trig_load  = |(trigger_load_in & ~trigger_disable_bits_in);
	wire wr_sw      = acc_write_in & hit_sw;
	wire wr_spare   = acc_write_in & hit_spare;

	// status read: answered reads of the status register clear it
	wire rd_normal  = acc_read_in & ~acc_broadcast_in;
	wire stat_read  = rd_normal & hit_status;

	// hardware events, one bit per flag
	wire [FLAG_W-1:0] flag_events = {
		err_cmd_parity_in,
		err_seq_length_in,
		err_addr_parity_in,
		err_data_parity_in,
		rd_normal & ~addr_ok,
		acc_write_in & ~addr_ok,
		acc_read_in & acc_broadcast_in
	};

	// set wins over clear so an event in the clearing cycle survives
	always_comb
	begin
		flags_next = flags_reg;
		if (full_rst)
		begin
			flags_next = RST_FLAGS;
		end
		else
		begin
			if (soft_rst | stat_read)
			begin
				flags_next = RST_FLAGS;
			end
			flags_next = flags_next | flag_events;
		end
	end

	// status flags register
	always_ff @(posedge clk_in)
	begin
		flags_reg <= flags_next;
	end

	// shadow copies take writes while triggers are live
	always_ff @(posedge clk_in)
	begin
		if (any_rst)
		begin
			sw_shadow_reg    <= RST_PATH_SELECTOR_FIELD;
			spare_shadow_reg <= RST_SPARE;
		end
		else
		begin
			if (wr_sw & ~direct_wr)
			begin
				sw_shadow_reg <= acc_wdata_in;
			end
			if (wr_spare & ~direct_wr)
			begin
				spare_shadow_reg <= acc_wdata_in;
			end
		end
	end

	// active registers: direct write, else trigger load from shadow
	always_ff @(posedge clk_in)
	begin
		if (any_rst)
		begin
			path_selector_field_reg <= RST_PATH_SELECTOR_FIELD;
			spare_reg   <= RST_SPARE;
		end
		else
		begin
			if (wr_sw & direct_wr)
			begin
				path_selector_field_reg <= acc_wdata_in;
			end
			else if (trig_load)
			begin
				path_selector_field_reg <= sw_shadow_reg;
			end
			if (wr_spare & direct_wr)
			begin
				spare_reg <= acc_wdata_in;
			end
			else if (trig_load)
			begin
				spare_reg <= spare_shadow_reg;
			end
		end
	end

	// selector decode; any other code and low power mean isolation
	wire [3:0] sel = path_selector_field_reg[SEL_MSB:0];
	always_comb
	begin
		case (sel)
			SEL_ONE:   throw_next = 4'h1;
			SEL_TWO:   throw_next = 4'h2;
			SEL_THREE: throw_next = 4'h4;
			SEL_FOUR:  throw_next = 4'h8;
			default:   throw_next = THROW_NONE;
		endcase
		if (power_low_in)
		begin
			throw_next = THROW_NONE;
		end
	end

	// throw enables come from flip-flops
	always_ff @(posedge clk_in)
	begin
		if (full_rst)
		begin
			throw_port_en_out <= THROW_NONE;
		end
		else
		begin
			throw_port_en_out <= throw_next;
		end
	end

	// read data mux; soft reset bit reads zero
	always_comb
	begin
		rdata_next = 8'h00;
		if (hit_sw)
		begin
			rdata_next = path_selector_field_reg;
		end
		else if (hit_spare)
		begin
			rdata_next = spare_reg;
		end
		else if (hit_status)
		begin
			rdata_next = {1'b0, flags_reg};
		end
	end

	// read answer one cycle after the request, only for owned addresses
	always_ff @(posedge clk_in)
	begin
		if (~reset_n_in)
		begin
			acc_rdata_out  <= 8'h00;
			acc_rvalid_out <= 1'b0;
		end
		else
		begin
			acc_rvalid_out <= rd_normal & hit_own;
			if (rd_normal & hit_own)
			begin
				acc_rdata_out <= rdata_next;
			end
		end
	end

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!reset_n_in);

	throw_one_hot_a: assert property ($onehot0(throw_port_en_out))
		else $error("more than one throw enabled");
	throw_decode_a: assert property ((sel == SEL_ONE && !power_low_in && !power_startup_in)
		|=> throw_port_en_out == 4'h1)
		else $error("selector one did not enable throw one");
	soft_reset_a: assert property ((soft_rst && !power_startup_in)
		|=> path_selector_field_reg == RST_PATH_SELECTOR_FIELD && spare_reg == RST_SPARE)
		else $error("soft reset left user registers set");
	status_top_zero_a: assert property (stat_read |=> acc_rvalid_out && !acc_rdata_out[7])
		else $error("soft reset bit read back as one");
	cmd_parity_set_a: assert property ((err_cmd_parity_in && !power_startup_in)
		|=> flags_reg[BIT_CMD_PAR])
		else $error("command parity flag not set");
	status_clear_a: assert property ((stat_read && flag_events == RST_FLAGS)
		|=> flags_reg == RST_FLAGS)
		else $error("status read did not clear flags");
	shadow_hold_a: assert property ((wr_sw && !direct_wr && !trig_load && !any_rst)
		|=> path_selector_field_reg == $past(path_selector_field_reg) && sw_shadow_reg == $past(acc_wdata_in))
		else $error("masked write reached active register");
	trigger_load_a: assert property ((trig_load && !acc_write_in && !any_rst)
		|=> path_selector_field_reg == $past(sw_shadow_reg))
		else $error("trigger did not load shadow");
	bad_write_a: assert property ((acc_write_in && !addr_ok && !power_startup_in)
		|=> flags_reg[BIT_BAD_WR])
		else $error("bad write address flag not set");
	shared_read_a: assert property ((acc_read_in && acc_broadcast_in && !power_startup_in)
		|=> flags_reg[BIT_SHR_RD] && !acc_rvalid_out)
		else $error("shared id read not flagged");
	startup_reset_a: assert property (power_startup_in
		|=> path_selector_field_reg == RST_PATH_SELECTOR_FIELD && flags_reg == RST_FLAGS ##1 throw_port_en_out == THROW_NONE)
		else $error("startup code did not reset registers");

endmodule

// File: verif/rfsw_host_model.sv
`timescale 1ns/1ps
// host side: the protocol engine's decoded strobes, one access at a time
module rfsw_host_model
(
	input  wire logic clk_in,    // system clock
	output logic      wr_out,    // write strobe
	output logic      rd_out,    // read strobe
	output logic      bcast_out, // shared id used
	output logic [15:0] addr_out, // register address
	output logic [7:0]  wdata_out // write data
);
	initial
	begin
		wr_out = 1'b0;
		rd_out = 1'b0;
		bcast_out = 1'b0;
		addr_out = 16'h0000;
		wdata_out = 8'h00;
	end
	// one write held over one rising edge, then address and data scrambled
	task automatic put(input logic [15:0] a, input logic [7:0] d);
		@(negedge clk_in);
		addr_out = a;
		wdata_out = d;
		wr_out = 1'b1;
		@(negedge clk_in);
		wr_out = 1'b0;
		addr_out = ~a;
		wdata_out = ~d;
	endtask
	// one read, optionally flagged as using a shared id
	task automatic get(input logic [15:0] a, input logic b);
		@(negedge clk_in);
		addr_out = a;
		bcast_out = b;
		rd_out = 1'b1;
		@(negedge clk_in);
		rd_out = 1'b0;
		bcast_out = 1'b0;
		addr_out = ~a;
	endtask
endmodule

// File: verif/test_rf_switch_serial_control_regs.sv
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin bad_count++; \
	$display("MISMATCH %0t got %h exp %h", $time, g, e); end end
module test_rf_switch_serial_control_regs;
	import rfsw_pkg::*;
	logic        clk_in = 1'b0;      // 50 MHz
	logic        reset_n_in = 1'b0;  // held low at start
	logic        claimed = 1'b0;     // address owned elsewhere
	logic [3:0]  err_v = 4'h0;       // data, addr, length, command parity events
	logic [2:0]  trig_load = 3'h0;   // trigger pulses
	logic [2:0]  trig_mask = 3'h7;   // all masked: direct writes
	logic        pwr_low = 1'b0;     // low power state
	logic        pwr_start = 1'b0;   // startup code
	logic        wr, rd, bc;         // host strobes
	logic [15:0] addr;               // host address
	logic [7:0]  wdata, rdata, v, p; // data and scratch
	logic        rvalid;             // read answer
	logic [3:0]  throws;             // throw enables
	int          bad_count = 0;      // mismatches
	int          checks_done = 0;    // comparisons
	int          i;
	always #10 clk_in = ~clk_in;
	rfsw_host_model host_u (.clk_in(clk_in), .wr_out(wr), .rd_out(rd), .bcast_out(bc),
		.addr_out(addr), .wdata_out(wdata));
	rfsw_regs dut_u (.clk_in(clk_in), .reset_n_in(reset_n_in), .acc_write_in(wr),
		.acc_read_in(rd), .acc_broadcast_in(bc), .acc_claimed_in(claimed),
		.acc_addr_in(addr), .acc_wdata_in(wdata), .err_cmd_parity_in(err_v[3]),
		.err_seq_length_in(err_v[2]), .err_addr_parity_in(err_v[1]),
		.err_data_parity_in(err_v[0]), .trigger_load_in(trig_load),
		.trigger_disable_bits_in(trig_mask), .power_low_in(pwr_low),
		.power_startup_in(pwr_start), .acc_rdata_out(rdata), .acc_rvalid_out(rvalid),
		.throw_port_en_out(throws));
	// expected throw enables: only the four one-hot codes connect
	function automatic logic [3:0] path_exp(input logic [3:0] s);
		return (s inside {SEL_ONE, SEL_TWO, SEL_THREE, SEL_FOUR}) ? s : THROW_NONE;
	endfunction
	// read that must be answered one cycle after it is taken
	task automatic rd_chk(input logic [15:0] a, input logic [7:0] e);
		host_u.get(a, 1'b0);
		`CHK(rvalid, 1'b1)
		`CHK(rdata, e)
	endtask
	task automatic tally_and_finish;
		if (bad_count == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// hang guard
	initial
	begin
		#200000;
		bad_count++;
		tally_and_finish();
	end
	initial
	begin
		void'($urandom(32'h9b394d31));
		repeat (4) @(negedge clk_in);
		reset_n_in = 1'b1;
		`CHK(throws, THROW_NONE)
		rd_chk(ADDR_PATH_SELECTOR_FIELD, RST_PATH_SELECTOR_FIELD);
		rd_chk(ADDR_SPARE, RST_SPARE);
		rd_chk(ADDR_STATUS, 8'h00);
		// selector codes: the four one-hot ones, upper nibble alone, then random
		for (i = 0; i < 14; i++)
		begin
			v = (i < 5) ? (8'h01 << i) : 8'($urandom);
			host_u.put(ADDR_PATH_SELECTOR_FIELD, v);
			@(negedge clk_in);
			`CHK(throws, path_exp(v[3:0]))
			rd_chk(ADDR_PATH_SELECTOR_FIELD, v);
			p = 8'($urandom);
			host_u.put(ADDR_SPARE, p);
			rd_chk(ADDR_SPARE, p);
		end
		pwr_low = 1'b1;
		repeat (2) @(negedge clk_in);
		`CHK(throws, THROW_NONE)
		pwr_low = 1'b0;
		repeat (2) @(negedge clk_in);
		`CHK(throws, path_exp(v[3:0]))
		// each frame error sets its own flag, a status read clears it
		for (i = 0; i < 4; i++)
		begin
			err_v[i] = 1'b1;
			@(negedge clk_in);
			err_v = 4'h0;
			rd_chk(ADDR_STATUS, 8'h08 << i);
			rd_chk(ADDR_STATUS, 8'h00);
		end
		host_u.get(16'h0005, 1'b0);
		`CHK(rvalid, 1'b0)
		host_u.put(16'h0002, 8'h5a);
		host_u.get(ADDR_PATH_SELECTOR_FIELD, 1'b1);
		`CHK(rvalid, 1'b0)
		claimed = 1'b1;
		host_u.put(16'h001c, 8'h00);
		claimed = 1'b0;
		rd_chk(ADDR_STATUS, 8'h07);
		// soft reset clears user registers and old flags; an event in its cycle still sets
		host_u.put(ADDR_PATH_SELECTOR_FIELD, 8'h42);
		host_u.get(16'h0005, 1'b0);    // bad read flag left standing
		err_v[0] = 1'b1;                // data parity event up to and in the reset cycle
		host_u.put(ADDR_STATUS, 8'h80);
		err_v = 4'h0;
		@(negedge clk_in);
		`CHK(throws, THROW_NONE)
		rd_chk(ADDR_PATH_SELECTOR_FIELD, RST_PATH_SELECTOR_FIELD);
		rd_chk(ADDR_SPARE, RST_SPARE);
		rd_chk(ADDR_STATUS, 8'h08);
		rd_chk(ADDR_STATUS, 8'h00);
		// one unmasked trigger at a time: write lands in shadow until loaded
		p = 8'h00;
		for (i = 0; i < 3; i++)
		begin
			trig_mask = ~(3'b001 << i);
			v = 8'h01 << i;
			host_u.put(ADDR_PATH_SELECTOR_FIELD, v);
			trig_load = trig_mask;       // masked triggers only: must not load
			@(negedge clk_in);
			trig_load = 3'h0;
			@(negedge clk_in);
			`CHK(throws, path_exp(p[3:0]))
			trig_load = 3'b001 << i;
			@(negedge clk_in);
			trig_load = 3'h0;
			@(negedge clk_in);
			`CHK(throws, v[3:0])
			p = v;
		end
		pwr_start = 1'b1;
		@(negedge clk_in);
		pwr_start = 1'b0;
		@(negedge clk_in);
		`CHK(throws, THROW_NONE)
		rd_chk(ADDR_PATH_SELECTOR_FIELD, RST_PATH_SELECTOR_FIELD);
		tally_and_finish();
	end
endmodule
